//--- cdi_flags.sv
// Bank of sticky event flags, set wins over clear
`timescale 1ns/10ps
module cdi_flags #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] USED = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Events and clears
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	output logic [WIDTH-1:0] flags_out
);
	// ==========================================================
	// Parameter check
	if (WIDTH < 1) begin : g_chk
		$error("cdi_flags width must be at least one");
	end
	// ==========================================================
	// One flag per bit; unused bits stay zero
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic flag_q;
		logic flag_d;
		// A set in the clearing cycle survives
		always_comb begin
			flag_d = USED[i] & (set_in[i] | (flag_q & ~clr_in[i]));
		end
		// Registers only
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				flag_q <= 1'b0;
			end else if (clk_en) begin
				flag_q <= flag_d;
			end
		end
		assign flags_out[i] = flag_q;
	end
endmodule // cdi_flags

//--- cdi_host.sv
// Serial bus controller model standing in for the host processor
`timescale 1ns/10ps
module cdi_host #(
	parameter logic [6:0] ADDR = 7'h35
) (
	// Clock
	input wire logic clk,
	// Bus lines
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// ==========================================================
	// Idle: clock driven high, data left to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// One third of a bit, well above the target's filter lag
	task automatic hp();
		repeat (8) @(posedge clk);
		#2;
	endtask
	// One bit; data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		hp();
		scl = 1'b1;
		hp();
		r = sda;
		scl = 1'b0;
		hp();
	endtask
	// Start, also repeated start
	task automatic start();
		sda_low = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b1;
		hp();
		scl = 1'b0;
		hp();
	endtask
	task automatic stop();
		sda_low = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b0;
		hp();
	endtask
	// Byte out, ack seen as data low
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic probe(input logic [6:0] a, output logic ack);
		start();
		byte_out({a, 1'b0}, ack);
		stop();
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic a;
		start();
		byte_out({ADDR, 1'b0}, a);
		byte_out(idx, a);
		byte_out(d, a);
		stop();
	endtask
	// Single byte read, ended by a refusal of the next byte
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		logic a;
		start();
		byte_out({ADDR, 1'b0}, a);
		byte_out(idx, a);
		start();
		byte_out({ADDR, 1'b1}, a);
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(1'b1, a);
		stop();
	endtask
endmodule // cdi_host

//--- cdi_pkg.sv
// Shared constants and carrier types for the charger-detect register bank
package cdi_pkg;
	// ==========================================================
	// Register indices
	localparam logic [7:0] REG_IDENTITY = 8'h00; // Identity codes
	localparam logic [7:0] REG_EVENT_FLAGS_ONE = 8'h01; // Sticky events, first group
	localparam logic [7:0] REG_EVENT_FLAGS_TWO = 8'h02; // Sticky events, second group
	localparam logic [7:0] REG_STATE_ONE = 8'h03; // Live detection status
	localparam logic [7:0] REG_STATE_TWO = 8'h04; // Live converter status
	localparam logic [7:0] REG_EVENT_ENABLE_ONE = 8'h05; // Masks for first group
	localparam logic [7:0] REG_EVENT_ENABLE_TWO = 8'h06; // Masks for second group
	localparam logic [7:0] REG_SETTINGS_ONE = 8'h07; // Control one
	localparam logic [7:0] REG_SETTINGS_TWO = 8'h08; // Control two
	localparam logic [7:0] REG_SETTINGS_THREE = 8'h09; // Control three
	// ==========================================================
	// Field positions
	localparam int BIT_CONTACT_TIMEOUT = 7; // Group one
	localparam int BIT_DETECT_BEGIN = 6;
	localparam int BIT_DETECT_END = 5;
	localparam int BIT_OVERVOLTAGE = 2;
	localparam int BIT_BUS_POWER_CHANGE = 1;
	localparam int BIT_PORT_CLASS = 0;
	localparam int BIT_CONVERTER_FAULT = 7; // Group two
	localparam int BIT_CONVERTER_CHANGE = 0;
	localparam int BIT_CHARGE_FORCE = 6; // Settings two
	localparam int BIT_CHARGE_VALUE = 5;
	// ==========================================================
	// Implemented bits and reset values
	localparam logic [7:0] USED_FLAGS_ONE = 8'he7; // Bits 4:3 reserved
	localparam logic [7:0] USED_FLAGS_TWO = 8'h81; // Bits 6:1 reserved
	localparam logic [7:0] WRITABLE_SETTINGS_THREE = 8'h4f; // Bit 7 zero, 5:4 reserved
	localparam logic [7:0] RESET_FLAGS = 8'h00;
	localparam logic [7:0] RESET_MASK = 8'h00;
	localparam logic [7:0] RESET_SETTINGS = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00; // Unmapped index answer
	// ==========================================================
	// Serial engine constants
	localparam logic [3:0] BYTE_BITS = 4'h8; // Bits per byte
	localparam logic [7:0] PTR_STEP = 8'h01; // Auto increment
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic contact_timeout_ev; // Pulse: contact timer expired
		logic detect_running; // Level: detection machine running
		logic over_voltage; // Level: bus above lockout threshold
		logic bus_above_detect; // Level: bus at or above detect level
		logic port_class_ev; // Pulse: charger type found
		logic converter_fault_ev; // Pulse: converter error
		logic converter_change_ev; // Pulse: converter result changed
	} cdi_events_s;
	typedef struct packed {
		logic contact_timer_state; // Timer wait status
		logic converter_fault_state; // Converter error status
		logic [3:0] port_class_state; // Charger type code
		logic [4:0] converter_level; // Converter output
	} cdi_status_s;
endpackage

//--- cdi_regs.sv
// Charger-detect register bank with serial target and open-drain outputs
// Overview of operation
// - Pull resistor-detect low on 80K sense
// - Interrupt pin active low, never driven high
// - Charger enable pin low enables charging
// - Serial target; clock input, data two-way
// - Contact timeout event sets flag bit 7
// - Detection start transition sets flag bit 6
// - Detection stop transition sets flag bit 5
// - Overvoltage rise sets flag bit 2
// - Any bus-power-good change sets bit 1
// - Charger type event sets flag bit 0
// - Converter error sets group-two bit 7
// - Mask bit one passes source, resets zero
// - Power good means detect level, no overvoltage
`timescale 1ns/10ps
module cdi_regs #(
	parameter logic [6:0] TARGET_ADDR = 7'h35, // Serial address, plain default
	parameter logic [3:0] MAKER_CODE = 4'h5, // Arbitrary value
	parameter logic [3:0] SILICON_REV = 4'h3 // Arbitrary value
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Detection logic side
	input wire cdi_pkg::cdi_events_s events_in,
	input wire cdi_pkg::cdi_status_s status_in,
	input wire logic charge_allow,
	input wire logic connector_sense_80k,
	// Open-drain outputs
	output logic irq_n_out,
	output logic irq_n_oe,
	output logic charge_enable_n_out,
	output logic charge_enable_n_oe,
	output logic resistor_detect_out,
	output logic resistor_detect_oe,
	// Control fields for the rest of the device
	output logic [7:0] settings_one_out,
	output logic [7:0] settings_two_out,
	output logic [7:0] settings_three_out
);
	// ==========================================================
	// Serial engine states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_INDEX,
		ST_WR_ACK,
		ST_WDATA,
		ST_RDATA,
		ST_RD_ACK
	} cdi_state_e;

	// ==========================================================
	// Pin synchronisers
	logic [1:0] pins_lvl; // {scl, sda} filtered
	cdi_sync3 #(
		.WIDTH(2),
		.RESET_VAL(2'h3)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.async_in({scl_in, sda_in}),
		.level_out(pins_lvl)
	);
	logic scl; // Filtered clock line
	logic sda; // Filtered data line
	assign scl = pins_lvl[1];
	assign sda = pins_lvl[0];

	// ==========================================================
	// Line history and bus conditions
	logic scl_prev_q; // Last cycle clock level
	logic sda_prev_q; // Last cycle data level
	logic scl_rise;
	logic scl_fall;
	logic bus_start; // Data falls, clock high
	logic bus_stop; // Data rises, clock high
	always_comb begin
		scl_rise = scl & ~scl_prev_q;
		scl_fall = ~scl & scl_prev_q;
		bus_start = scl & scl_prev_q & sda_prev_q & ~sda;
		bus_stop = scl & scl_prev_q & ~sda_prev_q & sda;
	end
	// History registers; idle bus is high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else if (clk_en) begin
			scl_prev_q <= scl;
			sda_prev_q <= sda;
		end
	end

	// ==========================================================
	// Register storage
	logic [7:0] enable_one_q; // Masks, first group
	logic [7:0] enable_one_d;
	logic [7:0] enable_two_q; // Masks, second group
	logic [7:0] enable_two_d;
	logic [7:0] set_one_q;
	logic [7:0] set_one_d;
	logic [7:0] set_two_q;
	logic [7:0] set_two_d;
	logic [7:0] set_three_q;
	logic [7:0] set_three_d;
	logic wr_stb; // Write of one data byte
	logic [7:0] wr_idx;
	logic [7:0] wr_val;
	// Decode writes; read-only indices ignore them
	always_comb begin
		enable_one_d = enable_one_q;
		enable_two_d = enable_two_q;
		set_one_d = set_one_q;
		set_two_d = set_two_q;
		set_three_d = set_three_q;
		if (wr_stb) begin
			unique case (wr_idx)
				cdi_pkg::REG_EVENT_ENABLE_ONE: begin
					enable_one_d = wr_val & cdi_pkg::USED_FLAGS_ONE;
				end
				cdi_pkg::REG_EVENT_ENABLE_TWO: begin
					enable_two_d = wr_val & cdi_pkg::USED_FLAGS_TWO;
				end
				cdi_pkg::REG_SETTINGS_ONE: begin
					set_one_d = wr_val;
				end
				cdi_pkg::REG_SETTINGS_TWO: begin
					set_two_d = wr_val;
				end
				cdi_pkg::REG_SETTINGS_THREE: begin
					set_three_d = wr_val & cdi_pkg::WRITABLE_SETTINGS_THREE;
				end
				default: begin
					// Read-only or unmapped: dropped silently
				end
			endcase
		end
	end
	// Register file flops; masks start closed
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_one_q <= cdi_pkg::RESET_MASK;
			enable_two_q <= cdi_pkg::RESET_MASK;
			set_one_q <= cdi_pkg::RESET_SETTINGS;
			set_two_q <= cdi_pkg::RESET_SETTINGS;
			set_three_q <= cdi_pkg::RESET_SETTINGS;
		end else if (clk_en) begin
			enable_one_q <= enable_one_d;
			enable_two_q <= enable_two_d;
			set_one_q <= set_one_d;
			set_two_q <= set_two_d;
			set_three_q <= set_three_d;
		end
	end

	// ==========================================================
	// Event edge detection
	logic run_prev_q; // Detection running, last cycle
	logic ovr_prev_q; // Overvoltage, last cycle
	logic good_prev_q; // Power good, last cycle
	logic power_good; // Live power-good status
	logic [7:0] set_grp_one;
	logic [7:0] set_grp_two;
	always_comb begin
		power_good = events_in.bus_above_detect & ~events_in.over_voltage;
		set_grp_one = 8'h00;
		set_grp_two = 8'h00;
		set_grp_one[cdi_pkg::BIT_CONTACT_TIMEOUT] = events_in.contact_timeout_ev;
		set_grp_one[cdi_pkg::BIT_DETECT_BEGIN] = events_in.detect_running & ~run_prev_q;
		set_grp_one[cdi_pkg::BIT_DETECT_END] = ~events_in.detect_running & run_prev_q;
		set_grp_one[cdi_pkg::BIT_OVERVOLTAGE] = events_in.over_voltage & ~ovr_prev_q;
		set_grp_one[cdi_pkg::BIT_BUS_POWER_CHANGE] = power_good ^ good_prev_q;
		set_grp_one[cdi_pkg::BIT_PORT_CLASS] = events_in.port_class_ev;
		set_grp_two[cdi_pkg::BIT_CONVERTER_FAULT] = events_in.converter_fault_ev;
		set_grp_two[cdi_pkg::BIT_CONVERTER_CHANGE] = events_in.converter_change_ev;
	end
	// Previous levels start low, so a high level at release is an edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_prev_q <= 1'b0;
			ovr_prev_q <= 1'b0;
			good_prev_q <= 1'b0;
		end else if (clk_en) begin
			run_prev_q <= events_in.detect_running;
			ovr_prev_q <= events_in.over_voltage;
			good_prev_q <= power_good;
		end
	end

	// ==========================================================
	// Sticky flags, cleared when read out
	logic rd_stb; // Byte loaded for sending
	logic [7:0] rd_idx;
	logic [7:0] clr_grp_one;
	logic [7:0] clr_grp_two;
	logic [7:0] flags_one;
	logic [7:0] flags_two;
	always_comb begin
		clr_grp_one = (rd_stb && rd_idx == cdi_pkg::REG_EVENT_FLAGS_ONE) ? 8'hff : 8'h00;
		clr_grp_two = (rd_stb && rd_idx == cdi_pkg::REG_EVENT_FLAGS_TWO) ? 8'hff : 8'h00;
	end
	cdi_flags #(
		.WIDTH(8),
		.USED(cdi_pkg::USED_FLAGS_ONE)
	) u_flags_one (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.set_in(set_grp_one),
		.clr_in(clr_grp_one),
		.flags_out(flags_one)
	);
	cdi_flags #(
		.WIDTH(8),
		.USED(cdi_pkg::USED_FLAGS_TWO)
	) u_flags_two (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.set_in(set_grp_two),
		.clr_in(clr_grp_two),
		.flags_out(flags_two)
	);

	// ==========================================================
	// Read multiplexer
	logic [7:0] rd_data;
	always_comb begin
		unique case (rd_idx)
			cdi_pkg::REG_IDENTITY: rd_data = {MAKER_CODE, SILICON_REV};
			cdi_pkg::REG_EVENT_FLAGS_ONE: rd_data = flags_one;
			cdi_pkg::REG_EVENT_FLAGS_TWO: rd_data = flags_two;
			cdi_pkg::REG_STATE_ONE: rd_data = {status_in.contact_timer_state,
				events_in.detect_running, events_in.over_voltage, power_good,
				status_in.port_class_state};
			cdi_pkg::REG_STATE_TWO: rd_data = {status_in.converter_fault_state, 2'h0,
				status_in.converter_level};
			cdi_pkg::REG_EVENT_ENABLE_ONE: rd_data = enable_one_q;
			cdi_pkg::REG_EVENT_ENABLE_TWO: rd_data = enable_two_q;
			cdi_pkg::REG_SETTINGS_ONE: rd_data = set_one_q;
			cdi_pkg::REG_SETTINGS_TWO: rd_data = set_two_q;
			cdi_pkg::REG_SETTINGS_THREE: rd_data = set_three_q;
			default: rd_data = cdi_pkg::READ_ZERO; // Unmapped reads zero
		endcase
	end

	// ==========================================================
	// Serial target engine
	cdi_state_e state_q;
	cdi_state_e state_d;
	logic [3:0] cnt_q; // Bits seen in this byte
	logic [3:0] cnt_d;
	logic [7:0] shift_q; // Receive or send shifter
	logic [7:0] shift_d;
	logic [7:0] ptr_q; // Register pointer
	logic [7:0] ptr_d;
	logic read_q; // Direction bit of address byte
	logic read_d;
	logic pull_q; // Holding data line low
	logic pull_d;
	logic acked_q; // Controller acked last byte
	logic acked_d;
	// Next-state logic; data only changes while clock is low
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		read_d = read_q;
		pull_d = pull_q;
		acked_d = acked_q;
		wr_stb = 1'b0;
		wr_idx = ptr_q;
		wr_val = shift_q;
		rd_stb = 1'b0;
		rd_idx = ptr_q;
		if (bus_start) begin
			// Start or repeated start wins over anything in flight
			state_d = ST_ADDR;
			cnt_d = 4'h0;
			pull_d = 1'b0;
		end else if (bus_stop) begin
			state_d = ST_IDLE;
			pull_d = 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					pull_d = 1'b0;
				end
				ST_ADDR, ST_INDEX, ST_WDATA: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == cdi_pkg::BYTE_BITS) begin
						pull_d = 1'b1; // Acknowledge by default
						if (state_q == ST_ADDR) begin
							if (shift_q[7:1] == TARGET_ADDR) begin
								read_d = shift_q[0];
								state_d = ST_ADDR_ACK;
							end else begin
								pull_d = 1'b0; // Not ours: stay off the bus
								state_d = ST_IDLE;
							end
						end else if (state_q == ST_INDEX) begin
							ptr_d = shift_q;
							state_d = ST_WR_ACK;
						end else begin
							wr_stb = 1'b1;
							ptr_d = ptr_q + cdi_pkg::PTR_STEP;
							state_d = ST_WR_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (read_q) begin
							rd_stb = 1'b1;
							shift_d = rd_data;
							pull_d = ~rd_data[7];
							state_d = ST_RDATA;
						end else begin
							pull_d = 1'b0;
							state_d = ST_INDEX;
						end
					end
				end
				ST_WR_ACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						pull_d = 1'b0;
						state_d = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == cdi_pkg::BYTE_BITS) begin
							pull_d = 1'b0; // Release for controller ack
							ptr_d = ptr_q + cdi_pkg::PTR_STEP;
							state_d = ST_RD_ACK;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							pull_d = ~shift_q[6];
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						acked_d = ~sda;
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (acked_q) begin
							rd_stb = 1'b1;
							shift_d = rd_data;
							pull_d = ~rd_data[7];
							state_d = ST_RDATA;
						end else begin
							state_d = ST_IDLE; // Not acked: wait for stop
						end
					end
				end
			endcase
		end
	end
	// Engine registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			read_q <= 1'b0;
			pull_q <= 1'b0;
			acked_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			read_q <= read_d;
			pull_q <= pull_d;
			acked_q <= acked_d;
		end
	end

	// ==========================================================
	// Open-drain pin drivers
	logic irq_oe_q; // Interrupt pin pulled low
	logic irq_oe_d;
	logic chg_oe_q; // Charger enable pulled low
	logic chg_oe_d;
	logic det_oe_q; // Resistor detect pulled low
	logic det_oe_d;
	// Pull-down requests; pins are never driven high
	always_comb begin
		irq_oe_d = |((flags_one & enable_one_q) | (flags_two & enable_two_q));
		chg_oe_d = set_two_q[cdi_pkg::BIT_CHARGE_FORCE] ?
			set_two_q[cdi_pkg::BIT_CHARGE_VALUE] : charge_allow;
		det_oe_d = connector_sense_80k;
	end
	// One cycle late relative to flags; outputs come straight from flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_oe_q <= 1'b0;
			chg_oe_q <= 1'b0;
			det_oe_q <= 1'b0;
		end else if (clk_en) begin
			irq_oe_q <= irq_oe_d;
			chg_oe_q <= chg_oe_d;
			det_oe_q <= det_oe_d;
		end
	end

	// ==========================================================
	// Port assignments; output levels are constant low
	assign sda_out = 1'b0;
	assign sda_oe = pull_q;
	assign irq_n_out = 1'b0;
	assign irq_n_oe = irq_oe_q;
	assign charge_enable_n_out = 1'b0;
	assign charge_enable_n_oe = chg_oe_q;
	assign resistor_detect_out = 1'b0;
	assign resistor_detect_oe = det_oe_q;
	assign settings_one_out = set_one_q;
	assign settings_two_out = set_two_q;
	assign settings_three_out = set_three_q;
endmodule // cdi_regs

//--- cdi_regs_checker.sv
// Assertion checker for the charger-detect register bank pins
`timescale 1ns/10ps
module cdi_regs_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Serial pins
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Detection side and outputs
	input wire logic charge_allow,
	input wire logic connector_sense_80k,
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	input wire logic charge_enable_n_out,
	input wire logic charge_enable_n_oe,
	input wire logic resistor_detect_out,
	input wire logic resistor_detect_oe,
	input wire logic [7:0] settings_two_out
);
	// ==========================================================
	// Helpers: serial clock seen low, wanted charger level
	logic scl_low_q; // No write can land before this
	logic scl_low_d;
	logic charge_want; // Forced value or detection request
	always_comb begin
		scl_low_d = scl_low_q | ~scl_in;
		charge_want = settings_two_out[6] ? settings_two_out[5] : charge_allow;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_low_q <= 1'b0;
		end else begin
			scl_low_q <= scl_low_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Properties
	property p_det_follow; clk_en |=> resistor_detect_oe == $past(connector_sense_80k); endproperty
	a_det_follow: assert property (p_det_follow) else $error("detect pin lag");
	property p_det_low; resistor_detect_out == 1'b0; endproperty
	a_det_low: assert property (p_det_low) else $error("detect pin driven high");
	property p_irq_low; irq_n_out == 1'b0; endproperty
	a_irq_low: assert property (p_irq_low) else $error("interrupt pin driven high");
	property p_chg_low; charge_enable_n_out == 1'b0; endproperty
	a_chg_low: assert property (p_chg_low) else $error("charger pin driven high");
	property p_chg_sel; clk_en |=> charge_enable_n_oe == $past(charge_want); endproperty
	a_chg_sel: assert property (p_chg_sel) else $error("charger enable wrong");
	property p_sda_low; sda_out == 1'b0; endproperty
	a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
	// Filter lag is at most four cycles, so six high cycles mean clock high inside
	property p_sda_hold; scl_in [*6] |-> $stable(sda_oe); endproperty
	a_sda_hold: assert property (p_sda_hold) else $error("data moved in clock high");
	property p_mask_rst; !scl_low_q |-> !irq_n_oe; endproperty
	a_mask_rst: assert property (p_mask_rst) else $error("interrupt before unmask");
	// ==========================================================
	// Main scenarios reached
	c_irq: cover property ($rose(irq_n_oe));
	c_ack: cover property ($rose(sda_oe));
	c_chg: cover property ($rose(charge_enable_n_oe));
endmodule // cdi_regs_checker

bind cdi_regs cdi_regs_checker i_cdi_regs_checker (.clk, .reset_n, .clk_en, .scl_in, .sda_out,
	.sda_oe, .charge_allow, .connector_sense_80k, .irq_n_out, .irq_n_oe, .charge_enable_n_out,
	.charge_enable_n_oe, .resistor_detect_out, .resistor_detect_oe, .settings_two_out);

//--- cdi_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module cdi_sync3 #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_out
);
	// ==========================================================
	// Parameter check
	if (WIDTH < 1) begin : g_chk
		$error("cdi_sync3 width must be at least one");
	end
	// ==========================================================
	// One chain per bit
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_q; // Metastable stage, read only by s2
		logic s2_q;
		logic s3_q;
		logic lvl_q;
		logic lvl_d;
		// Level moves only when the two settled stages agree
		always_comb begin
			lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
		end
		// Registers only
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				s1_q <= RESET_VAL[i];
				s2_q <= RESET_VAL[i];
				s3_q <= RESET_VAL[i];
				lvl_q <= RESET_VAL[i];
			end else if (clk_en) begin
				s1_q <= async_in[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				lvl_q <= lvl_d;
			end
		end
		assign level_out[i] = lvl_q;
	end
endmodule // cdi_sync3

//--- testbench.sv
// Self-checking bench for the charger-detect register bank
`timescale 1ns/10ps
module testbench;
	// ==========================================================
	// Signals
	localparam logic [3:0] MAKER = 4'h9; // Arbitrary value
	localparam logic [3:0] REV = 4'h6; // Arbitrary value
	logic clk, reset_n, clk_en, scl, host_low, sda_oe, sda_wire;
	cdi_pkg::cdi_events_s ev;
	cdi_pkg::cdi_status_s st;
	logic charge_allow, sense, irq_oe, chg_oe, det_oe, a;
	logic [7:0] s2, d, r;
	logic [15:0] e;
	int n_errors, checked;
	// Wired-and bus with pull-up
	assign sda_wire = ~(host_low | sda_oe);
	cdi_regs #(.MAKER_CODE(MAKER), .SILICON_REV(REV)) i_cdi_regs (.clk, .reset_n, .clk_en,
		.scl_in(scl), .sda_in(sda_wire), .sda_out(), .sda_oe, .events_in(ev), .status_in(st),
		.charge_allow, .connector_sense_80k(sense), .irq_n_out(), .irq_n_oe(irq_oe),
		.charge_enable_n_out(), .charge_enable_n_oe(chg_oe), .resistor_detect_out(),
		.resistor_detect_oe(det_oe), .settings_one_out(), .settings_two_out(s2),
		.settings_three_out());
	cdi_host i_cdi_host (.clk, .sda(sda_wire), .scl, .sda_low(host_low));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ==========================================================
	// Helpers
	task automatic tick();
		@(posedge clk);
		#2;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("Counts: %0d checks, %0d mismatches", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Flip one event line; pulses go back after one cycle
	task automatic ev_step(input int b, input logic lvl);
		ev[b] = ~ev[b];
		tick();
		if (!lvl) ev[b] = ~ev[b];
		tick();
		tick();
	endtask
	// Event table: line, level or pulse, and the flag it should leave
	localparam int EB [8] = '{6, 5, 5, 4, 3, 3, 2, 1};
	localparam bit EL [8] = '{0, 1, 1, 0, 1, 1, 0, 0};
	function automatic logic [15:0] ev_exp(input int k);
		case (k)
			0: return {cdi_pkg::REG_EVENT_FLAGS_ONE, 8'h80};
			1: return {cdi_pkg::REG_EVENT_FLAGS_ONE, 8'h40};
			2: return {cdi_pkg::REG_EVENT_FLAGS_ONE, 8'h20};
			3: return {cdi_pkg::REG_EVENT_FLAGS_ONE, 8'h04}; // Fall adds nothing
			4, 5: return {cdi_pkg::REG_EVENT_FLAGS_ONE, 8'h02};
			6: return {cdi_pkg::REG_EVENT_FLAGS_ONE, 8'h01};
			default: return {cdi_pkg::REG_EVENT_FLAGS_TWO, 8'h80};
		endcase
	endfunction
	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		$display("Error at %0t: run timed out", $time);
		wrap_up();
	end
	// ==========================================================
	// Main sequence
	initial begin
		ev = '0;
		st = '0;
		clk_en = 1'b1;
		charge_allow = 1'b0;
		sense = 1'b0;
		reset_n = 1'b0;
		n_errors = 0;
		checked = 0;
		r = 8'($urandom(32'h994a));
		repeat (20) @(posedge clk);
		#2;
		reset_n = 1'b1;
		repeat (4) tick();
		ev_step(6, 1'b0); // Masked flag before any access
		for (int i = 0; i < 11; i++) begin
			i_cdi_host.rd(8'(i), d);
			check(d, i == 0 ? {MAKER, REV} : (i == 1 ? 8'h80 : 8'h00));
		end
		$display("Test reset values done");
		i_cdi_host.probe(7'h36, a);
		check({7'h00, a}, 8'h00);
		i_cdi_host.probe(7'h35, a);
		check({7'h00, a}, 8'h01);
		$display("Test addressing done");
		for (int k = 0; k < 8; k++) begin
			ev_step(EB[k], EL[k]);
			e = ev_exp(k);
			i_cdi_host.rd(e[15:8], d);
			check(d, e[7:0]);
		end
		$display("Test event flags done");
		ev_step(3, 1'b1);
		i_cdi_host.rd(cdi_pkg::REG_STATE_ONE, d);
		check(d & 8'h10, 8'h10);
		ev_step(4, 1'b1);
		i_cdi_host.rd(cdi_pkg::REG_STATE_ONE, d);
		check(d & 8'h10, 8'h00);
		i_cdi_host.rd(cdi_pkg::REG_EVENT_FLAGS_ONE, d);
		check(d, 8'h06);
		$display("Test power good done");
		for (int j = 0; j < 2; j++) begin
			r = 8'($urandom);
			i_cdi_host.wr(cdi_pkg::REG_EVENT_ENABLE_ONE + 8'(j), r);
			i_cdi_host.rd(cdi_pkg::REG_EVENT_ENABLE_ONE + 8'(j), d);
			check(d, r & (j == 0 ? cdi_pkg::USED_FLAGS_ONE : cdi_pkg::USED_FLAGS_TWO));
		end
		i_cdi_host.wr(cdi_pkg::REG_EVENT_ENABLE_ONE, 8'h80);
		ev_step(2, 1'b0);
		check({7'h00, irq_oe}, 8'h00);
		ev_step(6, 1'b0);
		check({7'h00, irq_oe}, 8'h01);
		i_cdi_host.rd(cdi_pkg::REG_EVENT_FLAGS_ONE, d);
		check(d, 8'h81);
		check({7'h00, irq_oe}, 8'h00);
		clk_en = 1'b0;
		ev_step(6, 1'b0);
		clk_en = 1'b1;
		check({7'h00, irq_oe}, 8'h00);
		$display("Test interrupt done");
		for (int j = 0; j < 6; j++) begin
			r = (j == 0) ? 8'h40 : 8'($urandom);
			charge_allow = 1'($urandom);
			sense = 1'($urandom);
			i_cdi_host.wr(cdi_pkg::REG_SETTINGS_TWO, r);
			tick();
			check(s2, r);
			check({7'h00, chg_oe}, {7'h00, r[6] ? r[5] : charge_allow});
			check({7'h00, det_oe}, {7'h00, sense});
		end
		i_cdi_host.wr(cdi_pkg::REG_IDENTITY, 8'h00);
		i_cdi_host.rd(cdi_pkg::REG_IDENTITY, d);
		check(d, {MAKER, REV});
		$display("Test outputs done");
		wrap_up();
	end
endmodule // testbench
